// *** bench/stopwatch_alarm_compare_irq_tb.sv ***
`timescale 1ns/1ps
`define CHK(n, e, a) begin checks_done++; if ((a) !== (e)) begin err_total++; \
   $display("MISMATCH %s exp %h got %h", n, e, a); end end
module stopwatch_alarm_compare_irq_tb;
   logic mclk = 1'b0;
   logic srst = 1'b1;
   logic [39:0] tnow = '0;
   logic tick = 1'b0;
   logic [7:0] rdata;
   logic ia;
   logic ib;
   logic [7:0] d;
   logic [7:0] mreg [64];
   logic [1:0] fl = 2'b00;
   logic [1:0] pv = 2'b00;
   int err_total = 0;
   int checks_done = 0;
   swa_pkg::swa_req_t req;
   always #2.5 mclk = ~mclk;
   swa_host h (.clk(mclk), .req(req), .rdata(rdata));
   swa_alarm uut (.MCLK(mclk), .SRST(srst), .ADDR(req.addr), .WDATA(req.wdata), .WR(req.wr), .RD(req.rd),
      .RDATA(rdata), .TIME_NOW(tnow), .TIME_TICK(tick), .IRQ_OUT_A_N(ia), .IRQ_OUT_B_N(ib));
   // Model compare; a disabled field always agrees
   function automatic logic hit(int n, logic [39:0] t);
      logic [7:0] e;
      e = mreg[16];
      if (n == 0) return |e[4:0] && (!e[0] || mreg[8][6:0] == t[6:0]) && (!e[1] || mreg[9][6:0] == t[13:7]) &&
         (!e[2] || mreg[10] == t[23:16]) && (!e[3] || mreg[11] == t[31:24]) && (!e[4] || mreg[12] == t[39:32]);
      return |e[7:5] && (!e[5] || mreg[13][6:0] == t[13:7]) && (!e[6] || mreg[14] == t[23:16]) &&
         (!e[7] || mreg[15] == t[39:32]);
   endfunction
   // Writes also re-arm the model's match detector
   task automatic w(logic [5:0] a, logic [7:0] v);
      h.wr(a, v);
      pv = 2'b00;
      if (a == 6'h2b) fl &= ~v[1:0];
      else if (a != 6'h3f) mreg[a] = (a == 6'h08 || a == 6'h09 || a == 6'h0d) ? v & 8'h7f : (a > 6'h10 ? v & 8'h03 : v);
   endtask
   task automatic r(logic [5:0] a);
      h.rd(a, d);
      `CHK("rdata", (a == 6'h2b ? {6'h00, fl} : mreg[a]), d)
   endtask
   // One counter step; both pins looked at in the cycle after it, pin A also in the next
   task automatic tk(logic [39:0] t);
      logic [1:0] ns;
      ns = 2'b00;
      for (int n = 0; n < 2; n++) begin
         ns[n] = hit(n, t) && !pv[n];
         pv[n] = hit(n, t);
      end
      fl |= ns;
      @(posedge mclk);
      tnow <= t;
      tick <= 1'b1;
      @(posedge mclk);
      tick <= 1'b0;
      #1;
      `CHK("irq_a", ~|((mreg[46][1] ? ns : fl) & mreg[41][1:0]), ia)
      `CHK("irq_b", ~|((mreg[46][1] ? ns : fl) & mreg[42][1:0]), ib)
      @(posedge mclk);
      #1;
      `CHK("irq_a", ~|((mreg[46][1] ? 2'b00 : fl) & mreg[41][1:0]), ia)
   endtask
   task automatic stop_test;
      $display("checks %0d mismatches %0d", checks_done, err_total);
      if (err_total == 0 && checks_done > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask
   initial begin
      #100000;
      err_total++;
      stop_test;
   end
   initial begin
      for (int i = 0; i < 64; i++) mreg[i] = 8'h00;
      d = 8'($urandom(32'hd166));
      repeat (20) @(posedge mclk);
      srst <= 1'b0;
      for (int a = 8; a <= 16; a++) r(a[5:0]);
      $display("test reset done");
      // Random bytes, unimplemented top bits, an unmapped place
      for (int a = 8; a <= 16; a++) w(a[5:0], 8'($urandom));
      for (int a = 8; a <= 16; a++) r(a[5:0]);
      w(6'h3f, 8'hff);
      r(6'h3f);
      $display("test registers done");
      // Alarm one, level pins; minutes left out of the compare
      w(6'h2e, 8'h01);
      w(6'h29, 8'h01);
      w(6'h2a, 8'h02);
      w(6'h08, 8'h59);
      w(6'h0a, 8'h99);
      w(6'h0b, 8'h99);
      w(6'h0c, 8'h99);
      w(6'h10, 8'h1d);
      tk({24'h99_9999, 2'b00, 7'h12, 7'h58});
      tk({24'h99_9999, 2'b00, 7'h12, 7'h59});
      tk({24'h99_9999, 2'b00, 7'h12, 7'h59});
      r(6'h2b);
      w(6'h2b, 8'h01);
      tk({24'h99_9999, 2'b00, 7'h13, 7'h00});
      $display("test alarm one done");
      // Alarm two pulses again without a clear
      w(6'h2e, 8'h03);
      w(6'h29, 8'h02);
      w(6'h0d, 8'h30);
      w(6'h0e, 8'h42);
      w(6'h0f, 8'h17);
      w(6'h10, 8'he0);
      for (int k = 0; k < 4; k++) tk({24'h17_0042, 2'b00, 7'h30 + 7'(k % 2), 7'h00});
      w(6'h10, 8'h00);
      tk({24'h17_0042, 2'b00, 7'h30, 7'h00});
      r(6'h2b);
      $display("test alarm two done");
      stop_test;
   end
endmodule

// *** bench/swa_alarm_assertions.sv ***
`timescale 1ns/1ps
// Port-level checks on reads and interrupt pins
module swa_chk (
   // Clock and reset
   input wire logic MCLK,
   input wire logic SRST,
   // Register port
   input wire logic [5:0] ADDR,
   input wire logic [7:0] WDATA,
   input wire logic WR,
   input wire logic RD,
   input wire logic [7:0] RDATA,
   // Counter and pins
   input wire logic [39:0] TIME_NOW,
   input wire logic TIME_TICK,
   input wire logic IRQ_OUT_A_N,
   input wire logic IRQ_OUT_B_N
);
   default clocking @(posedge MCLK); endclocking
   default disable iff (SRST);
   logic pulse_r;
   logic [1:0] mask_r;
   // Shadow of pulse select and pin A mask, learnt from writes
   always_ff @(posedge MCLK) begin
      if (SRST) begin
         pulse_r <= 1'b0;
         mask_r <= 2'b00;
      end else if (WR && ADDR == 6'h2e) begin
         pulse_r <= WDATA[1];
      end else if (WR && ADDR == 6'h29) begin
         mask_r <= WDATA[1:0];
      end
   end
   rdata_idle_a: assert property (!RD |=> RDATA == 8'h00) else $error("read data out of slot");
   unmapped_zero_a: assert property (RD && ADDR == 6'h3f |=> RDATA == 8'h00) else $error("unmapped read");
   top_bit_a: assert property (RD && (ADDR == 6'h08 || ADDR == 6'h0d) |=> !RDATA[7]) else $error("bit 7");
   cause_pin_a: assert property ($fell(IRQ_OUT_A_N) |-> $past(TIME_TICK) || $past(WR) || $past(WR, 2))
      else $error("pin A fell");
   cause_pin_b_a: assert property ($fell(IRQ_OUT_B_N) |-> $past(TIME_TICK) || $past(WR) || $past(WR, 2))
      else $error("pin B fell");
   pulse_width_a: assert property (pulse_r && !IRQ_OUT_A_N |=> IRQ_OUT_A_N) else $error("pulse width");
   masked_pin_a: assert property ((mask_r == 2'b00) [*3] |-> IRQ_OUT_A_N) else $error("masked pin");
   level_hold_a: assert property (!pulse_r && !IRQ_OUT_A_N && !WR && !$past(WR) && !$past(WR, 2)
      |=> !IRQ_OUT_A_N) else $error("level dropped");
   cover property ($fell(IRQ_OUT_A_N));
   cover property ($fell(IRQ_OUT_B_N));
   cover property (RD && ADDR == 6'h2b);
endmodule
bind swa_alarm swa_chk u_chk (.MCLK(MCLK), .SRST(SRST), .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD),
   .RDATA(RDATA), .TIME_NOW(TIME_NOW), .TIME_TICK(TIME_TICK), .IRQ_OUT_A_N(IRQ_OUT_A_N), .IRQ_OUT_B_N(IRQ_OUT_B_N));

// *** bench/swa_host.sv ***
`timescale 1ns/1ps
// Host master; strobes last one cycle, no wait states
module swa_host (
   // Clock
   input wire logic clk,
   // Request out, read data in
   output swa_pkg::swa_req_t req,
   input wire logic [7:0] rdata
);
   initial req = '0;
   task automatic wr(input logic [5:0] a, input logic [7:0] d);
      @(posedge clk);
      req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
      @(posedge clk);
      req.wr <= 1'b0;
   endtask
   // Data stand only in the cycle after the strobe
   task automatic rd(input logic [5:0] a, output logic [7:0] d);
      @(posedge clk);
      req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
      @(posedge clk);
      req.rd <= 1'b0;
      #1 d = rdata;
   endtask
endmodule

// *** core/swa_alarm.sv ***
// The strobed register port was chosen for this implementation.
`timescale 1ns/1ps
`include "swa_defines.svh"
module swa_alarm (
   // Clock and reset
   input wire logic MCLK,
   input wire logic SRST,
   // Register port
   input wire logic [5:0] ADDR,
   input wire logic [7:0] WDATA,
   input wire logic WR,
   input wire logic RD,
   output logic [7:0] RDATA,
   // Elapsed-time counter and its increment strobe, same clock
   input wire logic [39:0] TIME_NOW,
   input wire logic TIME_TICK,
   // Active-low interrupt pins
   output logic IRQ_OUT_A_N,
   output logic IRQ_OUT_B_N
);
   swa_pkg::swa_req_t req;
   swa_pkg::swa_time_t now;
   assign req = '{addr: ADDR, wdata: WDATA, wr: WR, rd: RD};
   assign now = swa_pkg::swa_time_t'(TIME_NOW);

   // BCD byte compare; the unimplemented bit 7 is never compared
   function automatic logic eq7(input logic [7:0] a, input logic [6:0] b);
      eq7 = (a[6:0] == b);
   endfunction

   // BCD hour pair compare; both digits take part
   // All eight bits are digits here, nothing is masked off
   function automatic logic eq8(input logic [7:0] a, input logic [7:0] b);
      eq8 = (a == b);
   endfunction

   // Write strobe aimed at one offset
   // Keeps single-register decodes in one place
   function automatic logic wr_at(input swa_pkg::swa_req_t r, input logic [5:0] a);
      wr_at = r.wr && (r.addr == a);
   endfunction

   // Alarm one compare values
   // Seconds, minutes and three hour pairs
   logic [7:0] a1_sec_r;
   logic [7:0] a1_sec_nxt;
   logic [7:0] a1_min_r;
   logic [7:0] a1_min_nxt;
   logic [7:0] a1_hlo_r;
   logic [7:0] a1_hlo_nxt;
   logic [7:0] a1_hmid_r;
   logic [7:0] a1_hmid_nxt;
   logic [7:0] a1_hhi_r;
   logic [7:0] a1_hhi_nxt;
   // Alarm two compare values
   // Minutes and two hour pairs
   logic [7:0] a2_min_r;
   logic [7:0] a2_min_nxt;
   logic [7:0] a2_hlo_r;
   logic [7:0] a2_hlo_nxt;
   logic [7:0] a2_hhi_r;
   logic [7:0] a2_hhi_nxt;
   // Field enables and the two pin masks
   // All of them clear at reset
   logic [7:0] en_r;
   logic [7:0] en_nxt;
   logic [7:0] mask_a_r;
   logic [7:0] mask_a_nxt;
   logic [7:0] mask_b_r;
   logic [7:0] mask_b_nxt;
   // Sticky flags and mode control
   // Flag bit 0 is alarm one, bit 1 alarm two
   logic [1:0] flag_r;
   logic [1:0] flag_nxt;
   logic [1:0] ctrl_r;
   logic [1:0] ctrl_nxt;
   // Registered read data
   // Zero whenever no read was asked for
   logic [7:0] rdata_r;
   logic [7:0] rdata_nxt;
   // Registered pins, low while asserted
   // Idle high out of reset
   logic irq_a_n_r;
   logic irq_a_n_nxt;
   logic irq_b_n_r;
   logic irq_b_n_nxt;
   // Match detectors, one per alarm
   // Armed while the counter keeps matching
   swa_pkg::swa_state_t a1_st_r;
   swa_pkg::swa_state_t a1_st_nxt;
   swa_pkg::swa_state_t a2_st_r;
   swa_pkg::swa_state_t a2_st_nxt;
   // Combinational match terms
   // Match level, new hit and any-field-enabled per alarm
   logic m1;
   logic m2;
   logic hit1;
   logic hit2;
   logic any1;
   logic any2;

   // Alarm one compare; only enabled fields take part
   // Mode zero keeps both alarms quiet, the calendar layout is not built
   // An alarm with no field enabled would match always, so it is held off
   always_comb begin
      any1 = |en_r[`SWA_BIT_A1_HHI:`SWA_BIT_A1_SEC];
      m1 = any1 && ctrl_r[`SWA_BIT_CTRL_MODE];
      if (en_r[`SWA_BIT_A1_SEC] && !eq7(a1_sec_r, now.sec)) m1 = 1'b0;
      if (en_r[`SWA_BIT_A1_MIN] && !eq7(a1_min_r, now.min)) m1 = 1'b0;
      if (en_r[`SWA_BIT_A1_HLO] && !eq8(a1_hlo_r, now.hlo)) m1 = 1'b0;
      if (en_r[`SWA_BIT_A1_HMID] && !eq8(a1_hmid_r, now.hmid)) m1 = 1'b0;
      if (en_r[`SWA_BIT_A1_HHI] && !eq8(a1_hhi_r, now.hhi)) m1 = 1'b0;
   end

   // Alarm two compare; minutes and hour pairs only
   // It has no seconds field, so it hits at most once per matching minute unless a host write re-arms it
   always_comb begin
      any2 = |en_r[`SWA_BIT_A2_HHI:`SWA_BIT_A2_MIN];
      m2 = any2 && ctrl_r[`SWA_BIT_CTRL_MODE];
      if (en_r[`SWA_BIT_A2_MIN] && !eq7(a2_min_r, now.min)) m2 = 1'b0;
      if (en_r[`SWA_BIT_A2_HLO] && !eq8(a2_hlo_r, now.hlo)) m2 = 1'b0;
      if (en_r[`SWA_BIT_A2_HHI] && !eq8(a2_hhi_r, now.hhi)) m2 = 1'b0;
   end

   // Transition into match, evaluated only on a counter increment
   always_comb begin
      a1_st_nxt = a1_st_r;
      a2_st_nxt = a2_st_r;
      hit1 = 1'b0;
      hit2 = 1'b0;
      if (TIME_TICK) begin
         hit1 = m1 && (a1_st_r == swa_pkg::SWA_IDLE);
         hit2 = m2 && (a2_st_r == swa_pkg::SWA_IDLE);
         a1_st_nxt = m1 ? swa_pkg::SWA_ARMED : swa_pkg::SWA_IDLE;
         a2_st_nxt = m2 ? swa_pkg::SWA_ARMED : swa_pkg::SWA_IDLE;
      end
      // Any host write re-arms so a fresh setting can hit
      if (req.wr) begin
         a1_st_nxt = swa_pkg::SWA_IDLE;
         a2_st_nxt = swa_pkg::SWA_IDLE;
      end
   end

   // Alarm one values; bit 7 of seconds and minutes is dropped
   // Reads then show zero there, so software sees what is compared
   always_comb begin
      a1_sec_nxt = a1_sec_r;
      a1_min_nxt = a1_min_r;
      a1_hlo_nxt = a1_hlo_r;
      a1_hmid_nxt = a1_hmid_r;
      a1_hhi_nxt = a1_hhi_r;
      if (req.wr) begin
         case (req.addr)
            `SWA_OFF_A1_SEC: a1_sec_nxt = {1'b0, req.wdata[6:0]};
            `SWA_OFF_A1_MIN: a1_min_nxt = {1'b0, req.wdata[6:0]};
            `SWA_OFF_A1_HLO: a1_hlo_nxt = req.wdata;
            `SWA_OFF_A1_HMID: a1_hmid_nxt = req.wdata;
            `SWA_OFF_A1_HHI: a1_hhi_nxt = req.wdata;
            default: ;
         endcase
      end
   end

   // Alarm two values
   // Minutes and the two hour pairs only; there is no seconds byte
   always_comb begin
      a2_min_nxt = a2_min_r;
      a2_hlo_nxt = a2_hlo_r;
      a2_hhi_nxt = a2_hhi_r;
      if (req.wr) begin
         case (req.addr)
            `SWA_OFF_A2_MIN: a2_min_nxt = {1'b0, req.wdata[6:0]};
            `SWA_OFF_A2_HLO: a2_hlo_nxt = req.wdata;
            `SWA_OFF_A2_HHI: a2_hhi_nxt = req.wdata;
            default: ;
         endcase
      end
   end

   // Field enables and pin masks
   // Masks keep only the two alarm bits; the rest read back zero
   always_comb begin
      en_nxt = en_r;
      mask_a_nxt = mask_a_r;
      mask_b_nxt = mask_b_r;
      if (req.wr) begin
         case (req.addr)
            `SWA_OFF_ENABLES: en_nxt = req.wdata;
            `SWA_OFF_IRQ_A_MASK: mask_a_nxt = {6'h00, req.wdata[1:0]};
            `SWA_OFF_IRQ_B_MASK: mask_b_nxt = {6'h00, req.wdata[1:0]};
            default: ;
         endcase
      end
   end

   // Mode select and pin style
   // A mode change is seen by the compare from the next cycle on
   always_comb begin
      ctrl_nxt = ctrl_r;
      if (wr_at(req, `SWA_OFF_CTRL)) begin
         ctrl_nxt = req.wdata[1:0];
      end
   end

   // Sticky flags, write one to clear
   // A hit in the same cycle as a clear wins, so no match is lost
   always_comb begin
      flag_nxt = flag_r;
      if (wr_at(req, `SWA_OFF_FLAGS)) begin
         flag_nxt = flag_r & ~req.wdata[1:0];
      end
      if (hit1) flag_nxt[`SWA_BIT_FLAG_A1] = 1'b1;
      if (hit2) flag_nxt[`SWA_BIT_FLAG_A2] = 1'b1;
   end

   // Read mux, data valid in the cycle after the strobe
   always_comb begin
      rdata_nxt = 8'h00;
      if (req.rd) begin
         case (req.addr)
            `SWA_OFF_A1_SEC: rdata_nxt = a1_sec_r;
            `SWA_OFF_A1_MIN: rdata_nxt = a1_min_r;
            `SWA_OFF_A1_HLO: rdata_nxt = a1_hlo_r;
            `SWA_OFF_A1_HMID: rdata_nxt = a1_hmid_r;
            `SWA_OFF_A1_HHI: rdata_nxt = a1_hhi_r;
            `SWA_OFF_A2_MIN: rdata_nxt = a2_min_r;
            `SWA_OFF_A2_HLO: rdata_nxt = a2_hlo_r;
            `SWA_OFF_A2_HHI: rdata_nxt = a2_hhi_r;
            `SWA_OFF_ENABLES: rdata_nxt = en_r;
            `SWA_OFF_IRQ_A_MASK: rdata_nxt = mask_a_r;
            `SWA_OFF_IRQ_B_MASK: rdata_nxt = mask_b_r;
            `SWA_OFF_FLAGS: rdata_nxt = {6'h00, flag_r};
            `SWA_OFF_CTRL: rdata_nxt = {6'h00, ctrl_r};
            default: rdata_nxt = 8'h00;
         endcase
      end
   end

   // Interrupt pins; level mode follows flags, pulse mode lasts one cycle per hit
   always_comb begin
      if (ctrl_r[`SWA_BIT_CTRL_PULSE]) begin
         irq_a_n_nxt = !((hit1 && mask_a_r[`SWA_BIT_IE_A1]) || (hit2 && mask_a_r[`SWA_BIT_IE_A2]));
         irq_b_n_nxt = !((hit1 && mask_b_r[`SWA_BIT_IE_A1]) || (hit2 && mask_b_r[`SWA_BIT_IE_A2]));
      end else begin
         irq_a_n_nxt = !(|(flag_nxt & mask_a_r[1:0]));
         irq_b_n_nxt = !(|(flag_nxt & mask_b_r[1:0]));
      end
   end

   // Alarm one registers
   // Cleared at reset, though only enabled fields ever matter
   always_ff @(posedge MCLK) begin
      if (SRST) begin
         a1_sec_r <= `SWA_RST_BYTE;
         a1_min_r <= `SWA_RST_BYTE;
         a1_hlo_r <= `SWA_RST_BYTE;
         a1_hmid_r <= `SWA_RST_BYTE;
         a1_hhi_r <= `SWA_RST_BYTE;
      end else begin
         a1_sec_r <= a1_sec_nxt;
         a1_min_r <= a1_min_nxt;
         a1_hlo_r <= a1_hlo_nxt;
         a1_hmid_r <= a1_hmid_nxt;
         a1_hhi_r <= a1_hhi_nxt;
      end
   end

   // Alarm two registers
   // Same reset policy as alarm one
   always_ff @(posedge MCLK) begin
      if (SRST) begin
         a2_min_r <= `SWA_RST_BYTE;
         a2_hlo_r <= `SWA_RST_BYTE;
         a2_hhi_r <= `SWA_RST_BYTE;
      end else begin
         a2_min_r <= a2_min_nxt;
         a2_hlo_r <= a2_hlo_nxt;
         a2_hhi_r <= a2_hhi_nxt;
      end
   end

   // Enable and mask registers
   // Everything off after reset, so no alarm can fire by accident
   always_ff @(posedge MCLK) begin
      if (SRST) begin
         en_r <= `SWA_RST_ENABLES;
         mask_a_r <= `SWA_RST_BYTE;
         mask_b_r <= `SWA_RST_BYTE;
      end else begin
         en_r <= en_nxt;
         mask_a_r <= mask_a_nxt;
         mask_b_r <= mask_b_nxt;
      end
   end

   // Control register
   // Reset leaves the compare off and the pins in level style
   always_ff @(posedge MCLK) begin
      if (SRST) begin
         ctrl_r <= 2'b00;
      end else begin
         ctrl_r <= ctrl_nxt;
      end
   end

   // Flag register
   // Only a host write clears it outside reset
   always_ff @(posedge MCLK) begin
      if (SRST) begin
         flag_r <= 2'b00;
      end else begin
         flag_r <= flag_nxt;
      end
   end

   // Read data register
   // Registered so the port output comes straight from a flip-flop
   // The cost is one cycle of read latency, which the host expects
   always_ff @(posedge MCLK) begin
      if (SRST) begin
         rdata_r <= `SWA_RST_BYTE;
      end else begin
         rdata_r <= rdata_nxt;
      end
   end

   // Interrupt pin registers
   // Registered pins cannot glitch while the compare settles
   // The price is one cycle between the tick and the pin
   always_ff @(posedge MCLK) begin
      if (SRST) begin
         irq_a_n_r <= 1'b1;
         irq_b_n_r <= 1'b1;
      end else begin
         irq_a_n_r <= irq_a_n_nxt;
         irq_b_n_r <= irq_b_n_nxt;
      end
   end

   // Match detector state
   // Idle after reset, so a value matching at once still counts
   always_ff @(posedge MCLK) begin
      if (SRST) begin
         a1_st_r <= swa_pkg::SWA_IDLE;
         a2_st_r <= swa_pkg::SWA_IDLE;
      end else begin
         a1_st_r <= a1_st_nxt;
         a2_st_r <= a2_st_nxt;
      end
   end

   assign RDATA = rdata_r;
   assign IRQ_OUT_A_N = irq_a_n_r;
   assign IRQ_OUT_B_N = irq_b_n_r;
endmodule

// *** core/swa_defines.svh ***
`ifndef SWA_DEFINES_SVH
`define SWA_DEFINES_SVH
// Register offsets (index = byte address on the plain port)
`define SWA_OFF_A1_SEC 6'h08
`define SWA_OFF_A1_MIN 6'h09
`define SWA_OFF_A1_HLO 6'h0a
`define SWA_OFF_A1_HMID 6'h0b
`define SWA_OFF_A1_HHI 6'h0c
`define SWA_OFF_A2_MIN 6'h0d
`define SWA_OFF_A2_HLO 6'h0e
`define SWA_OFF_A2_HHI 6'h0f
`define SWA_OFF_ENABLES 6'h10
`define SWA_OFF_IRQ_A_MASK 6'h29
`define SWA_OFF_IRQ_B_MASK 6'h2a
`define SWA_OFF_FLAGS 6'h2b
`define SWA_OFF_CTRL 6'h2e
// Enable register bit positions
`define SWA_BIT_A2_HHI 7
`define SWA_BIT_A2_HLO 6
`define SWA_BIT_A2_MIN 5
`define SWA_BIT_A1_HHI 4
`define SWA_BIT_A1_HMID 3
`define SWA_BIT_A1_HLO 2
`define SWA_BIT_A1_MIN 1
`define SWA_BIT_A1_SEC 0
// Interrupt mask bits, flags bits, control bits
`define SWA_BIT_IE_A1 0
`define SWA_BIT_IE_A2 1
`define SWA_BIT_FLAG_A1 0
`define SWA_BIT_FLAG_A2 1
`define SWA_BIT_CTRL_MODE 0
`define SWA_BIT_CTRL_PULSE 1
// Reset values
`define SWA_RST_BYTE 8'h00
`define SWA_RST_ENABLES 8'h00
`endif

// *** core/swa_pkg.sv ***
package swa_pkg;
   // Running elapsed-time counter, BCD
   typedef struct packed {
      logic [7:0] hhi;
      logic [7:0] hmid;
      logic [7:0] hlo;
      logic [1:0] spare;
      logic [6:0] min;
      logic [6:0] sec;
   } swa_time_t;
   // Host register port request
   typedef struct packed {
      logic [5:0] addr;
      logic [7:0] wdata;
      logic wr;
      logic rd;
   } swa_req_t;
   typedef enum logic [0:0] {
      SWA_IDLE,
      SWA_ARMED
   } swa_state_t;
endpackage
